// >>> rtl/wdt_pkg.sv
package wdt_pkg;
    // register map of the special function space
    localparam logic [7:0] PWR_CTRL_ADDR     = 8'h87;
    localparam logic [7:0] WDOG_COUNT_ADDR   = 8'hff;
    // field positions in the power control register
    localparam int         UNLOCK_FLAG_BIT   = 4;
    localparam int         PDOWN_REQ_BIT     = 1;
    // reset values
    localparam logic [7:0] PWR_CTRL_RST      = 8'h00;
    localparam logic [7:0] WDOG_COUNT_RST    = 8'h00;
    localparam logic [10:0] PRESC_RST        = 11'h000;
    // timing: machine cycle is twelve clocks, prescaler spans 2048 machine cycles
    localparam int         CLK_PER_MCYC      = 12;
    localparam logic [3:0] MCYC_LAST         = 4'(CLK_PER_MCYC - 1);
    localparam logic [10:0] PRESC_LAST       = 11'h7ff;
    localparam int         RST_PULSE_MCYC    = 3;
    localparam logic [5:0] RST_PULSE_CLKS    = 6'(RST_PULSE_MCYC * CLK_PER_MCYC);

    // register bus request from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wdt_bus_req_t;
endpackage

// >>> rtl/wdt_timer.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - the watchdog is an 8-bit counter stepped by the terminal count of an 11-bit prescaler.
// - the prescaler advances once per machine cycle, one twelfth of the clock.
// - the counter steps once every 2048 machine cycles.
// - an overflow while enabled raises a short internal reset for the whole controller.
// - an overflow also drives a three machine cycle pulse on the reset pin, independent of it.
// - a low enable pin enables the watchdog and software cannot disable it.
// - a high enable pin keeps the watchdog disabled with no overflow reset.
// - a counter write is ignored unless the unlock flag is set at the time.
// - an accepted counter write clears the unlock flag.
// - the counter counts up, so 00 gives the longest and ff the shortest interval.
// - prescaler and counter keep running during idle.
// - while enabled, setting the power-down request bit is ignored and it stays 0.
// - the counter sits at address ff and the power control register at 87.
module wdt_timer (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire wdt_pkg::wdt_bus_req_t bus_req,
    output logic [7:0]                 rdata,
    input  wire logic                  watchdog_enable_n_pin,
    input  wire logic                  idle_mode,
    output logic                       powerdown_req,
    output logic                       sys_reset_pulse,
    output logic                       reset_pin_pulse
);

    logic [3:0]  mcyc_reg;
    logic [10:0] presc_reg;
    logic [7:0]  wdog_count_reg;
    logic [7:0]  pwr_ctrl_reg;
    logic [5:0]  pin_cnt_reg;
    logic        wd_enabled;
    logic        mcyc_tick;
    logic        presc_tc;
    logic        unlock_flag;
    logic        reload_ok;
    logic        overflow;

    ////////////////////////////////////////////////////////////////////////////
    // decode and timing terms
    assign wd_enabled  = ~watchdog_enable_n_pin;
    assign mcyc_tick   = (mcyc_reg == wdt_pkg::MCYC_LAST);
    assign presc_tc    = mcyc_tick && (presc_reg == wdt_pkg::PRESC_LAST);
    assign unlock_flag = pwr_ctrl_reg[wdt_pkg::UNLOCK_FLAG_BIT];
    assign reload_ok   = bus_req.wr && (bus_req.addr == wdt_pkg::WDOG_COUNT_ADDR)
                         && unlock_flag;
    assign overflow    = presc_tc && (wdog_count_reg == 8'hff) && wd_enabled;

    ////////////////////////////////////////////////////////////////////////////
    // machine cycle divider; idle_mode is deliberately not used so counting goes on
    always_ff @(posedge clk)
    begin
        if (!rst_n || overflow || reload_ok)
            mcyc_reg <= 4'h0;
        else if (mcyc_tick)
            mcyc_reg <= 4'h0;
        else
            mcyc_reg <= mcyc_reg + 4'h1;
    end

    // 11-bit prescaler, restarted by a reload so the new interval starts at the write
    always_ff @(posedge clk)
    begin
        if (!rst_n || overflow || reload_ok)
            presc_reg <= wdt_pkg::PRESC_RST;
        else if (mcyc_tick)
            presc_reg <= presc_reg + 11'h001;
    end

    // up-counter; a reload wins over a same-cycle step
    always_ff @(posedge clk)
    begin
        if (!rst_n || overflow)
            wdog_count_reg <= wdt_pkg::WDOG_COUNT_RST;
        else if (reload_ok)
            wdog_count_reg <= bus_req.wdata;
        else if (presc_tc)
            wdog_count_reg <= wdog_count_reg + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // power control: unlock flag and power-down request, other bits plain storage
    always_ff @(posedge clk)
    begin
        if (!rst_n || overflow)
            pwr_ctrl_reg <= wdt_pkg::PWR_CTRL_RST;
        else if (bus_req.wr && bus_req.addr == wdt_pkg::PWR_CTRL_ADDR)
        begin
            pwr_ctrl_reg <= bus_req.wdata;
            if (wd_enabled)
                pwr_ctrl_reg[wdt_pkg::PDOWN_REQ_BIT] <= 1'b0;
        end
        else
        begin
            if (reload_ok)
                pwr_ctrl_reg[wdt_pkg::UNLOCK_FLAG_BIT] <= 1'b0;
            if (wd_enabled)
                pwr_ctrl_reg[wdt_pkg::PDOWN_REQ_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, valid only the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (bus_req.rd && bus_req.addr == wdt_pkg::WDOG_COUNT_ADDR)
            rdata <= wdog_count_reg;
        else if (bus_req.rd && bus_req.addr == wdt_pkg::PWR_CTRL_ADDR)
            rdata <= pwr_ctrl_reg;
        else
            rdata <= 8'h00;                                           // unmapped reads zero
    end

    // one-cycle internal reset; downstream stretches it as it likes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sys_reset_pulse <= 1'b0;
        else
            sys_reset_pulse <= overflow;
    end

    // pin pulse runs on its own counter so the internal reset never waits for it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pin_cnt_reg <= 6'h00;
        else if (overflow)
            pin_cnt_reg <= wdt_pkg::RST_PULSE_CLKS;
        else if (pin_cnt_reg != 6'h00)
            pin_cnt_reg <= pin_cnt_reg - 6'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reset_pin_pulse <= 1'b0;
        else
            reset_pin_pulse <= overflow || (pin_cnt_reg > 6'h01);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            powerdown_req <= 1'b0;
        else
            powerdown_req <= pwr_ctrl_reg[wdt_pkg::PDOWN_REQ_BIT] && !wd_enabled;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_rst_pulse_cause: assert property (@(posedge clk) disable iff (!rst_n)
        sys_reset_pulse |-> $past(presc_tc) && $past(wd_enabled))
        else $error("internal reset without enabled overflow");
    a_disabled_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
        $past(watchdog_enable_n_pin) |-> !sys_reset_pulse)
        else $error("reset while watchdog disabled");
    a_pin_pulse_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sys_reset_pulse) |-> reset_pin_pulse [*8])
        else $error("pin pulse too short");
    a_unlock_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_req.wr && bus_req.addr == wdt_pkg::WDOG_COUNT_ADDR && !unlock_flag && !presc_tc
         && !overflow) |=> $stable(wdog_count_reg))
        else $error("locked counter write took effect");
    a_unlock_clears: assert property (@(posedge clk) disable iff (!rst_n)
        reload_ok |=> !unlock_flag && wdog_count_reg == $past(bus_req.wdata))
        else $error("reload did not clear unlock");
    a_pdown_blocked: assert property (@(posedge clk) disable iff (!rst_n)
        wd_enabled && $past(wd_enabled) |-> !pwr_ctrl_reg[wdt_pkg::PDOWN_REQ_BIT])
        else $error("power-down set while enabled");
    a_step_rate: assert property (@(posedge clk) disable iff (!rst_n)
        (wdog_count_reg != $past(wdog_count_reg)) |-> $past(presc_tc) || $past(reload_ok)
        || $past(overflow))
        else $error("counter moved off terminal count");
    a_presc_restart: assert property (@(posedge clk) disable iff (!rst_n)
        reload_ok |=> presc_reg == 11'h000 && mcyc_reg == 4'h0)
        else $error("prescaler not restarted");
    // three machine cycles on the pin, and not one clock more
    a_pin_pulse_exact: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(reset_pin_pulse) |-> ##35 reset_pin_pulse ##1 !reset_pin_pulse)
        else $error("pin pulse length wrong");
    c_pin_pulse: cover property (@(posedge clk) $fell(reset_pin_pulse));
    c_reload: cover property (@(posedge clk) reload_ok);
    c_overflow: cover property (@(posedge clk) sys_reset_pulse);
    c_pdown_try: cover property (@(posedge clk) wd_enabled && bus_req.wr
        && bus_req.addr == wdt_pkg::PWR_CTRL_ADDR && bus_req.wdata[1]);

endmodule

`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic                  clk = 1'b0;
    logic                  rst_n;
    logic                  pin_n;
    logic                  idle;
    wdt_pkg::wdt_bus_req_t bus_req;
    logic [7:0]            rdata;
    logic                  pdown;
    logic                  sys_rst;
    logic                  pin_rst;
    int                    resets;
    int                    fails = 0;
    int                    n_checks = 0;
    int                    seed = 32'h25f78c9b;
    int                    pin_hi = 0;
    int                    n;
    logic [7:0]            v;
    logic [7:0]            a;
    logic                  rd_d = 1'b0;
    logic [7:0]            q[$];

    always #2 clk = ~clk;

    wdt_core_model core_u (.clk(clk), .bus_req(bus_req), .sys_reset_pulse(sys_rst),
                           .resets(resets));
    wdt_timer dut_u (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
                     .watchdog_enable_n_pin(pin_n), .idle_mode(idle),
                     .powerdown_req(pdown), .sys_reset_pulse(sys_rst),
                     .reset_pin_pulse(pin_rst));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (e !== g)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // note the expectation, then issue the read
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        q.push_back(e);
        core_u.acc(ad, 8'h00, 1'b0);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_d)
            chk("rdata", q.pop_front(), rdata);
        if (pin_rst === 1'b1)
            pin_hi <= pin_hi + 1;
        rd_d <= bus_req.rd;
    end

    // hang guard, well beyond the two long waits
    initial
    begin
        repeat (70000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial
    begin
        rst_n = 1'b0;
        pin_n = 1'b1;
        idle  = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(wdt_pkg::PWR_CTRL_ADDR, 8'h00);
        rd(wdt_pkg::WDOG_COUNT_ADDR, 8'h00);
        core_u.acc(wdt_pkg::WDOG_COUNT_ADDR, 8'h5a, 1'b1);
        rd(wdt_pkg::WDOG_COUNT_ADDR, 8'h00);
        v = 8'($random(seed));
        core_u.reload(v);
        rd(wdt_pkg::WDOG_COUNT_ADDR, v);
        rd(wdt_pkg::PWR_CTRL_ADDR, 8'h00);
        do
            a = 8'($random(seed));
        while (a == 8'h87 || a == 8'hff);
        rd(a, 8'h00);
        core_u.acc(wdt_pkg::PWR_CTRL_ADDR, 8'h02, 1'b1);
        repeat (2) @(posedge clk);
        chk("powerdown", 8'h01, {7'h00, pdown});
        pin_n <= 1'b0;
        core_u.acc(wdt_pkg::PWR_CTRL_ADDR, 8'h02, 1'b1);
        rd(wdt_pkg::PWR_CTRL_ADDR, 8'h00);
        @(posedge clk);
        chk("powerdown", 8'h00, {7'h00, pdown});
        // shortest interval, with idle on to show it keeps counting
        idle <= 1'b1;
        core_u.reload(8'hff);
        pin_hi = 0;
        n = 0;
        while (sys_rst !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            n++;
        end
        chk("interval", 8'h01, {7'h00, n >= 24570 && n <= 24582});
        repeat (40) @(posedge clk);
        chk("pin width", 8'd36, 8'(pin_hi));
        chk("resets", 8'd1, 8'(resets));
        rd(wdt_pkg::WDOG_COUNT_ADDR, 8'h00);
        pin_n <= 1'b1;
        core_u.reload(8'hff);
        repeat (24700) @(posedge clk);
        chk("resets", 8'd1, 8'(resets));
        finish_test();
    end
endmodule

`default_nettype wire

// >>> verif/wdt_core_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// core side: register bus master and the system reset logic
module wdt_core_model (
    input  wire logic             clk,
    output wdt_pkg::wdt_bus_req_t bus_req,
    input  wire logic             sys_reset_pulse,
    output var int                resets
);
    initial
    begin
        bus_req = '0;
        resets  = 0;
    end

    // reset logic only tallies pulses, the bench judges them
    always @(posedge clk)
    begin
        if (sys_reset_pulse)
            resets <= resets + 1;
    end

    // one strobe cycle, then inverted lines so stale values never match
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // unlock first, then load the counter
    task automatic reload(input logic [7:0] v);
        acc(wdt_pkg::PWR_CTRL_ADDR, 8'h10, 1'b1);
        acc(wdt_pkg::WDOG_COUNT_ADDR, v, 1'b1);
    endtask
endmodule

`default_nettype wire
